// ==== common/mci_pkg.sv ====
// constants, field positions and carriers for the misc control block
// assumes one system clock and an 8-bit register port from the mpu
//
// How it works
// RULE1: route y pulse to pin nine when set
// RULE2: debug clock bit stops emulator clock
// RULE3: debug clock bit refuses external erase/program
// RULE4: four local enables gate four interrupt sources
// RULE5: interrupt passes only with local and mpu enable; o_irq rises from status and mask alone, with neither enable
// RULE6: conversion field turns pins four/five into eeprom
package mci_pkg;

  // ********************************
  // register offsets
  // ********************************
  localparam logic [15:0] ADDR_EE_DATA = 16'h009e; // eeprom data
  localparam logic [15:0] ADDR_EE_CTRL = 16'h009f; // eeprom control
  localparam logic [15:0] ADDR_EQN = 16'h2000; // equation select
  localparam logic [15:0] ADDR_IEN_A = 16'h2002; // xfr, rtc enables
  localparam logic [15:0] ADDR_DBG = 16'h2005; // debug clock disable
  localparam logic [15:0] ADDR_IEN_B = 16'h2007; // collision, pll enables
  localparam logic [15:0] ADDR_EEX = 16'h2008; // pin conversion
  localparam logic [15:0] ADDR_ROUTE = 16'h200f; // y pulse route
  localparam logic [15:0] ADDR_IRQ_STAT = 16'h2100; // sticky status
  localparam logic [15:0] ADDR_IRQ_MASK = 16'h2101; // status mask

  // ********************************
  // field positions
  // ********************************
  localparam int EQN_LSB = 5; // equation field low bit
  localparam int EQN_MSB = 7; // equation field high bit
  localparam int XFR_BIT = 0; // transfer enable in ien_a
  localparam int RTC_BIT = 1; // tick enable in ien_a
  localparam int COLL_BIT = 4; // collision enable in ien_b
  localparam int PLL_BIT = 5; // pll enable in ien_b
  localparam int DBG_BIT = 5; // debug clock disable
  localparam int EEX_LSB = 6; // conversion field low bit
  localparam int EEX_MSB = 7; // conversion field high bit
  localparam int ROUTE_BIT = 2; // y pulse route bit

  // ********************************
  // interrupt source indices
  // ********************************
  localparam int NIRQ = 4; // number of sources
  localparam int IRQ_XFR = 0; // transfer busy
  localparam int IRQ_RTC = 1; // one-second tick
  localparam int IRQ_COLL = 2; // firmware collision
  localparam int IRQ_PLL = 3; // pll

  // ********************************
  // reset values
  // ********************************
  localparam logic [7:0] RST_BYTE = 8'h00; // all registers
  localparam logic [2:0] RST_EQN = 3'h0; // equation select
  localparam logic [1:0] RST_EEX = 2'h0; // conversion field
  localparam logic [3:0] RST_IRQ = 4'h0; // enables, status, mask

  // one driven pin: level and enable
  typedef struct packed {
    logic out; // level driven
    logic oe; // high while driving
  } mci_pin_s;

  // external programming request gate
  typedef enum logic [2:0] {
    GATE_IDLE = 3'h1, // waiting for a request
    GATE_GRANT = 3'h2, // forwarding one request
    GATE_REFUSE = 3'h4 // reporting one refusal
  } mci_gate_e;

endpackage

// ==== core/mci_sync2.sv ====
// two-flop synchroniser for one pin level
// assumes the level is asynchronous to i_sys_clk
`timescale 1ns/1ps
`default_nettype none
module mci_sync2 (
  input wire logic i_sys_clk, // system clock
  input wire logic i_resetn, // synchronous reset, low
  input wire logic i_d, // raw pin level
  output logic o_q // synchronised level
);

  // ********************************
  // two stages
  // ********************************
  logic meta_r; // first stage, read only by o_q

  // only the second stage is visible outside
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      meta_r <= 1'b0;
      o_q <= 1'b0;
    end else begin
      meta_r <= i_d;
      o_q <= meta_r;
    end
  end

endmodule
`default_nettype wire

// ==== core/mci_pin_mux.sv ====
// registered pin multiplexer: normal function or alternate function
// assumes both sources are on i_sys_clk
`timescale 1ns/1ps
`default_nettype none
module mci_pin_mux (
  input wire logic i_sys_clk, // system clock
  input wire logic i_resetn, // synchronous reset, low
  input wire logic i_sel_alt, // high selects alternate
  input wire mci_pkg::mci_pin_s i_norm, // normal function drive
  input wire mci_pkg::mci_pin_s i_alt, // alternate drive
  output var mci_pkg::mci_pin_s o_pin // registered pin drive
);

  // ********************************
  // output register
  // ********************************
  // registered so the pin never glitches while the select flips;
  // costs one cycle of latency on both paths
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_pin <= '0; // released after reset
    end else if (i_sel_alt) begin
      o_pin <= i_alt;
    end else begin
      o_pin <= i_norm;
    end
  end

endmodule
`default_nettype wire

// ==== core/mci_misc_ctrl.sv ====
// misc control register slice: pin routing, eeprom pins, debug
// clock lockout and local interrupt enables
// assumes an 8-bit mpu register port on i_sys_clk (25 MHz) and
// event pulses from on-chip logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module mci_misc_ctrl (
  input wire logic i_sys_clk, // system clock, 25 MHz
  input wire logic i_resetn, // synchronous reset, low
  // register port
  input wire logic [15:0] i_addr, // register address
  input wire logic [7:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [7:0] o_rdata, // read data, one cycle later
  // interrupt sources and mpu side
  input wire logic [3:0] i_events, // source pulses
  input wire logic [3:0] i_mpu_ex_en, // mpu external enables
  output logic [3:0] o_mpu_irq, // gated source pulses
  output logic o_irq, // level, unmasked status set
  // eeprom engine and control outputs
  input wire logic i_ee_sck, // eeprom serial clock
  input wire logic i_ee_sda_out, // eeprom data level
  input wire logic i_ee_sda_oe, // eeprom data enable
  output logic o_ee_sda_in, // synchronised data line
  output logic [7:0] o_ee_data, // eeprom data register
  output logic [7:0] o_ee_ctrl, // eeprom control register
  output logic [2:0] o_eqn_sel, // equation select
  // normal pin functions
  input wire logic [2:0] i_norm_out, // pins 4, 5, 9 levels
  input wire logic [2:0] i_norm_oe, // pins 4, 5, 9 enables
  input wire logic i_aux_energy_pulse_y, // y energy pulse
  // pins
  input wire logic i_pin5_in, // pin five level
  output logic o_pin4_out, // pin four level
  output logic o_pin4_oe, // pin four enable
  output logic o_pin5_out, // pin five level
  output logic o_pin5_oe, // pin five enable
  output logic o_pin9_out, // pin nine level
  output logic o_pin9_oe, // pin nine enable
  // debug port
  input wire logic i_ext_erase_req, // erase request pulse
  input wire logic i_ext_prog_req, // program request pulse
  output logic o_debug_clk_en, // debug clock enable
  output logic o_erase_go, // erase granted pulse
  output logic o_prog_go, // program granted pulse
  output logic o_ext_refused // request refused pulse
);

  // ********************************
  // register state
  // ********************************
  logic [7:0] ee_data_r; // eeprom data
  logic [7:0] ee_ctrl_r; // eeprom control
  logic [2:0] eqn_r; // equation select
  logic [3:0] ien_r; // local interrupt enables
  logic debug_clock_disable_r; // emulator clock off
  logic [1:0] eeprom_pin_conversion_r; // eeprom pin field
  logic y_pulse_pin_route_r; // y pulse to pin nine
  logic [3:0] stat_r; // sticky event status
  logic [3:0] mask_r; // status mask
  logic [3:0] stat_nxt; // next status
  logic [7:0] rdata_nxt; // next read data

  // ********************************
  // write decode
  // ********************************
  logic wr_ee_data; // strobe per register
  logic wr_ee_ctrl;
  logic wr_eqn;
  logic wr_ien_a;
  logic wr_dbg;
  logic wr_ien_b;
  logic wr_eex;
  logic wr_route;
  logic wr_stat;
  logic wr_mask;

  // one strobe per address; unmapped writes hit nothing
  always_comb begin
    wr_ee_data = 1'b0;
    wr_ee_ctrl = 1'b0;
    wr_eqn = 1'b0;
    wr_ien_a = 1'b0;
    wr_dbg = 1'b0;
    wr_ien_b = 1'b0;
    wr_eex = 1'b0;
    wr_route = 1'b0;
    wr_stat = 1'b0;
    wr_mask = 1'b0;
    if (!i_wr) begin
      wr_ee_data = 1'b0; // no write this cycle
    end else if (i_addr == mci_pkg::ADDR_EE_DATA) begin
      wr_ee_data = 1'b1;
    end else if (i_addr == mci_pkg::ADDR_EE_CTRL) begin
      wr_ee_ctrl = 1'b1;
    end else if (i_addr == mci_pkg::ADDR_EQN) begin
      wr_eqn = 1'b1;
    end else if (i_addr == mci_pkg::ADDR_IEN_A) begin
      wr_ien_a = 1'b1;
    end else if (i_addr == mci_pkg::ADDR_DBG) begin
      wr_dbg = 1'b1;
    end else if (i_addr == mci_pkg::ADDR_IEN_B) begin
      wr_ien_b = 1'b1;
    end else if (i_addr == mci_pkg::ADDR_EEX) begin
      wr_eex = 1'b1;
    end else if (i_addr == mci_pkg::ADDR_ROUTE) begin
      wr_route = 1'b1;
    end else if (i_addr == mci_pkg::ADDR_IRQ_STAT) begin
      wr_stat = 1'b1;
    end else if (i_addr == mci_pkg::ADDR_IRQ_MASK) begin
      wr_mask = 1'b1;
    end
  end

  // ********************************
  // eeprom and equation registers
  // ********************************
  // plain storage; their meaning lives in other blocks
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      ee_data_r <= mci_pkg::RST_BYTE;
      ee_ctrl_r <= mci_pkg::RST_BYTE;
      eqn_r <= mci_pkg::RST_EQN;
    end else begin
      if (wr_ee_data) begin
        ee_data_r <= i_wdata;
      end
      if (wr_ee_ctrl) begin
        ee_ctrl_r <= i_wdata;
      end
      if (wr_eqn) begin
        eqn_r <= i_wdata[mci_pkg::EQN_MSB:mci_pkg::EQN_LSB];
      end
    end
  end

  // ********************************
  // local interrupt enables
  // ********************************
  // two sources share each byte; other bits of the byte are not kept
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      ien_r <= mci_pkg::RST_IRQ;
    end else begin
      if (wr_ien_a) begin // see RULE4
        ien_r[mci_pkg::IRQ_XFR] <= i_wdata[mci_pkg::XFR_BIT];
        ien_r[mci_pkg::IRQ_RTC] <= i_wdata[mci_pkg::RTC_BIT];
      end
      if (wr_ien_b) begin // see RULE4
        ien_r[mci_pkg::IRQ_COLL] <= i_wdata[mci_pkg::COLL_BIT];
        ien_r[mci_pkg::IRQ_PLL] <= i_wdata[mci_pkg::PLL_BIT];
      end
    end
  end

  // ********************************
  // pin and debug control bits
  // ********************************
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      debug_clock_disable_r <= 1'b0;
      eeprom_pin_conversion_r <= mci_pkg::RST_EEX;
      y_pulse_pin_route_r <= 1'b0;
    end else begin
      if (wr_dbg) begin
        debug_clock_disable_r <= i_wdata[mci_pkg::DBG_BIT];
      end
      if (wr_eex) begin
        eeprom_pin_conversion_r <=
          i_wdata[mci_pkg::EEX_MSB:mci_pkg::EEX_LSB];
      end
      if (wr_route) begin
        y_pulse_pin_route_r <= i_wdata[mci_pkg::ROUTE_BIT];
      end
    end
  end

  // ********************************
  // sticky status and mask
  // ********************************
  // set wins over a write-one clear in the same cycle, so an event
  // landing on the clear is never lost
  always_comb begin
    stat_nxt = stat_r;
    if (wr_stat) begin
      stat_nxt = stat_nxt & ~i_wdata[mci_pkg::NIRQ-1:0];
    end
    stat_nxt = stat_nxt | i_events;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      stat_r <= mci_pkg::RST_IRQ;
      mask_r <= mci_pkg::RST_IRQ;
    end else begin
      stat_r <= stat_nxt;
      if (wr_mask) begin
        mask_r <= i_wdata[mci_pkg::NIRQ-1:0];
      end
    end
  end

  // level output from the present status; follows status by one cycle
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(stat_r & mask_r);
    end
  end

  // ********************************
  // mpu interrupt gating
  // ********************************
  // a source reaches the mpu only with both enables set
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_mpu_irq <= mci_pkg::RST_IRQ;
    end else begin
      o_mpu_irq <= i_events & ien_r & i_mpu_ex_en; // see RULE5
    end
  end

  // ********************************
  // read path
  // ********************************
  // unmapped addresses and unused bits read as zero
  always_comb begin
    rdata_nxt = mci_pkg::RST_BYTE;
    if (i_addr == mci_pkg::ADDR_EE_DATA) begin
      rdata_nxt = ee_data_r;
    end else if (i_addr == mci_pkg::ADDR_EE_CTRL) begin
      rdata_nxt = ee_ctrl_r;
    end else if (i_addr == mci_pkg::ADDR_EQN) begin
      rdata_nxt[mci_pkg::EQN_MSB:mci_pkg::EQN_LSB] = eqn_r;
    end else if (i_addr == mci_pkg::ADDR_IEN_A) begin
      rdata_nxt[mci_pkg::XFR_BIT] = ien_r[mci_pkg::IRQ_XFR];
      rdata_nxt[mci_pkg::RTC_BIT] = ien_r[mci_pkg::IRQ_RTC];
    end else if (i_addr == mci_pkg::ADDR_DBG) begin
      rdata_nxt[mci_pkg::DBG_BIT] = debug_clock_disable_r;
    end else if (i_addr == mci_pkg::ADDR_IEN_B) begin
      rdata_nxt[mci_pkg::COLL_BIT] = ien_r[mci_pkg::IRQ_COLL];
      rdata_nxt[mci_pkg::PLL_BIT] = ien_r[mci_pkg::IRQ_PLL];
    end else if (i_addr == mci_pkg::ADDR_EEX) begin
      rdata_nxt[mci_pkg::EEX_MSB:mci_pkg::EEX_LSB] =
        eeprom_pin_conversion_r;
    end else if (i_addr == mci_pkg::ADDR_ROUTE) begin
      rdata_nxt[mci_pkg::ROUTE_BIT] = y_pulse_pin_route_r;
    end else if (i_addr == mci_pkg::ADDR_IRQ_STAT) begin
      rdata_nxt[mci_pkg::NIRQ-1:0] = stat_r;
    end else if (i_addr == mci_pkg::ADDR_IRQ_MASK) begin
      rdata_nxt[mci_pkg::NIRQ-1:0] = mask_r;
    end
  end

  // data stand only in the cycle after the strobe, zero otherwise
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_rdata <= mci_pkg::RST_BYTE;
    end else if (i_rd) begin
      o_rdata <= rdata_nxt;
    end else begin
      o_rdata <= mci_pkg::RST_BYTE;
    end
  end

  // register copies for the eeprom engine and the metering core
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_ee_data <= mci_pkg::RST_BYTE;
      o_ee_ctrl <= mci_pkg::RST_BYTE;
      o_eqn_sel <= mci_pkg::RST_EQN;
    end else begin
      o_ee_data <= ee_data_r;
      o_ee_ctrl <= ee_ctrl_r;
      o_eqn_sel <= eqn_r;
    end
  end

  // ********************************
  // debug clock and request gate
  // ********************************
  // the enable drives the clock gate of the emulator port
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_debug_clk_en <= 1'b1;
    end else begin
      o_debug_clk_en <= ~debug_clock_disable_r; // see RULE2
    end
  end

  mci_pkg::mci_gate_e gate_r; // request gate state
  logic gate_is_erase_r; // granted request was an erase

  // one request at a time; requests arriving outside idle are dropped,
  // a limit the programmer must respect by spacing them
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      gate_r <= mci_pkg::GATE_IDLE;
      gate_is_erase_r <= 1'b0;
    end else begin
      case (gate_r)
        mci_pkg::GATE_IDLE: begin
          if (i_ext_erase_req || i_ext_prog_req) begin
            gate_is_erase_r <= i_ext_erase_req;
            if (debug_clock_disable_r) begin // see RULE3
              gate_r <= mci_pkg::GATE_REFUSE;
            end else begin
              gate_r <= mci_pkg::GATE_GRANT;
            end
          end
        end
        mci_pkg::GATE_GRANT: begin
          gate_r <= mci_pkg::GATE_IDLE;
        end
        mci_pkg::GATE_REFUSE: begin
          gate_r <= mci_pkg::GATE_IDLE;
        end
        default: begin
          gate_r <= mci_pkg::GATE_IDLE; // recover from a bad code
        end
      endcase
    end
  end

  // outputs register the gate decision; lockout rechecked at grant
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_erase_go <= 1'b0;
      o_prog_go <= 1'b0;
      o_ext_refused <= 1'b0;
    end else begin
      o_erase_go <= (gate_r == mci_pkg::GATE_GRANT) &&
                    gate_is_erase_r && !debug_clock_disable_r;
      o_prog_go <= (gate_r == mci_pkg::GATE_GRANT) &&
                   !gate_is_erase_r && !debug_clock_disable_r;
      o_ext_refused <= (gate_r == mci_pkg::GATE_REFUSE) ||
                       ((gate_r == mci_pkg::GATE_GRANT) &&
                        debug_clock_disable_r); // see RULE3
    end
  end

  // ********************************
  // pin multiplexing
  // ********************************
  logic ee_mode; // pins four and five serve the eeprom
  mci_pkg::mci_pin_s norm4, norm5, norm9; // normal drives
  mci_pkg::mci_pin_s alt4, alt5, alt9; // alternate drives
  mci_pkg::mci_pin_s pin4, pin5, pin9; // registered drives

  // any nonzero value of the field converts the pins
  assign ee_mode = |eeprom_pin_conversion_r; // see RULE6
  assign norm4 = '{out: i_norm_out[0], oe: i_norm_oe[0]};
  assign norm5 = '{out: i_norm_out[1], oe: i_norm_oe[1]};
  assign norm9 = '{out: i_norm_out[2], oe: i_norm_oe[2]};
  assign alt4 = '{out: i_ee_sck, oe: 1'b1}; // clock always driven
  assign alt5 = '{out: i_ee_sda_out, oe: i_ee_sda_oe};
  assign alt9 = '{out: i_aux_energy_pulse_y, oe: 1'b1};

  // pin four becomes the serial clock
  mci_pin_mux u_pin4 (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_sel_alt(ee_mode), // see RULE6
    .i_norm(norm4),
    .i_alt(alt4),
    .o_pin(pin4)
  );

  // pin five becomes the two-way data line
  mci_pin_mux u_pin5 (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_sel_alt(ee_mode), // see RULE6
    .i_norm(norm5),
    .i_alt(alt5),
    .o_pin(pin5)
  );

  // pin nine carries the y pulse in place of its normal use
  mci_pin_mux u_pin9 (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_sel_alt(y_pulse_pin_route_r), // see RULE1
    .i_norm(norm9),
    .i_alt(alt9),
    .o_pin(pin9)
  );

  // incoming data level is asynchronous to the system clock
  mci_sync2 u_sda_sync (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_d(i_pin5_in),
    .o_q(o_ee_sda_in)
  );

  assign o_pin4_out = pin4.out;
  assign o_pin4_oe = pin4.oe;
  assign o_pin5_out = pin5.out;
  assign o_pin5_oe = pin5.oe;
  assign o_pin9_out = pin9.out;
  assign o_pin9_oe = pin9.oe;

endmodule
`default_nettype wire

// ==== tb/mci_misc_ctrl_properties.sv ====
// port assertions for the misc control register slice
// assumes a bind onto mci_misc_ctrl, one clock, sync low reset
`timescale 1ns/1ps
`default_nettype none
module mci_misc_ctrl_properties (
  input wire logic i_sys_clk, // system clock
  input wire logic i_resetn, // sync reset, low
  input wire logic [15:0] i_addr, // register address
  input wire logic [7:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  input wire logic [7:0] o_rdata, // read data
  input wire logic [3:0] i_events, // source pulses
  input wire logic [3:0] i_mpu_ex_en, // mpu enables
  input wire logic [3:0] o_mpu_irq, // gated pulses
  input wire logic i_pin5_in, // pin five pad
  input wire logic o_ee_sda_in, // synced data line
  input wire logic i_ext_erase_req, // erase request
  input wire logic i_ext_prog_req, // program request
  input wire logic o_debug_clk_en, // debug clock runs
  input wire logic o_erase_go, // erase granted
  input wire logic o_prog_go, // program granted
  input wire logic o_ext_refused // request refused
);
  // ****************************************
  // clocking and request shapes
  // ****************************************
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_resetn);
  // the clock enable lags the bit, so its next value shows the lock
  sequence s_req_locked;
    (i_ext_erase_req || i_ext_prog_req) ##1 !o_debug_clk_en;
  endsequence
  // the lock is checked at request and again at grant
  sequence s_prog_open;
    (i_ext_prog_req && !i_ext_erase_req) ##1 o_debug_clk_en [*2];
  endsequence
  // ****************************************
  // assertions
  // ****************************************
  chk_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data not zero outside a read");
  chk_dbg_stop: assert property (
    i_wr && i_addr == mci_pkg::ADDR_DBG && i_wdata[mci_pkg::DBG_BIT]
    |-> ##2 !o_debug_clk_en) else $error("debug clock still on");
  chk_dbg_run: assert property (
    i_wr && i_addr == mci_pkg::ADDR_DBG && !i_wdata[mci_pkg::DBG_BIT]
    |-> ##2 o_debug_clk_en) else $error("debug clock still off");
  chk_locked_refuse: assert property (s_req_locked |-> ##1
    (o_ext_refused && !o_erase_go && !o_prog_go))
    else $error("locked request not refused");
  chk_prog_grant: assert property (s_prog_open |->
    (o_prog_go && !o_ext_refused)) else $error("program not granted");
  chk_go_pulse: assert property ((o_prog_go || o_erase_go)
    |=> !o_prog_go && !o_erase_go) else $error("grant not one cycle");
  chk_irq_gate: assert property (o_mpu_irq != 4'h0 |->
    (o_mpu_irq & ~($past(i_events) & $past(i_mpu_ex_en))) == 4'h0)
    else $error("mpu interrupt without event and enable");
  chk_sda_sync: assert property (
    $past(i_resetn) && $past(i_resetn, 2)
    |-> o_ee_sda_in == $past(i_pin5_in, 2))
    else $error("data line sync latency wrong");
endmodule
bind mci_misc_ctrl mci_misc_ctrl_properties u_props (.i_sys_clk,
  .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_events,
  .i_mpu_ex_en, .o_mpu_irq, .i_pin5_in, .o_ee_sda_in, .i_ext_erase_req,
  .i_ext_prog_req, .o_debug_clk_en, .o_erase_go, .o_prog_go,
  .o_ext_refused);
`default_nettype wire

// ==== tb/mci_misc_ctrl_tb_top.sv ====
// self-checking bench for the misc control register slice
// assumes the dut alone; every input is driven here on the clock edge
`timescale 1ns/1ps
`default_nettype none
module mci_misc_ctrl_tb_top;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0; // bus controls
  logic [15:0] addr = 16'h0000; // register address
  logic [7:0] wdata = 8'h00, rdata, ee_data, ee_ctrl; // data paths
  logic [3:0] ev = 4'h0, ex_en = 4'h0, mpu_irq; // interrupt side
  logic [2:0] norm_out = 3'h0, norm_oe = 3'h0, eqn; // normal pin drive
  logic sck = 1'b0, sda_o = 1'b0, sda_oe = 1'b0, pin5 = 1'b0; // eeprom
  logic ypul = 1'b0, erq = 1'b0, prq = 1'b0; // pulse and requests
  logic irq, sda_in, p4o, p4e, p5o, p5e, p9o, p9e, dbg_en, e_go, p_go, refd;
  int n_errors = 0, comparisons = 0; // verdict counters
  // map table; 0x2003 is unmapped and must read zero
  logic [15:0] ra [10] = '{16'h009e, 16'h009f, 16'h2000, 16'h2002,
    16'h2003, 16'h2005, 16'h2007, 16'h2008, 16'h200f, 16'h2101};
  logic [7:0] rm [10] = '{8'hff, 8'hff, 8'he0, 8'h03, 8'h00, 8'h20,
    8'h30, 8'hc0, 8'h04, 8'h0f};
  always #20 clk = ~clk;
  mci_misc_ctrl dut (.i_sys_clk(clk), .i_resetn(rst_n), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_events(ev), .i_mpu_ex_en(ex_en), .o_mpu_irq(mpu_irq), .o_irq(irq),
    .i_ee_sck(sck), .i_ee_sda_out(sda_o), .i_ee_sda_oe(sda_oe),
    .o_ee_sda_in(sda_in), .o_ee_data(ee_data), .o_ee_ctrl(ee_ctrl),
    .o_eqn_sel(eqn), .i_norm_out(norm_out), .i_norm_oe(norm_oe),
    .i_aux_energy_pulse_y(ypul), .i_pin5_in(pin5), .o_pin4_out(p4o),
    .o_pin4_oe(p4e), .o_pin5_out(p5o), .o_pin5_oe(p5e), .o_pin9_out(p9o),
    .o_pin9_oe(p9e), .i_ext_erase_req(erq), .i_ext_prog_req(prq),
    .o_debug_clk_en(dbg_en), .o_erase_go(e_go), .o_prog_go(p_go),
    .o_ext_refused(refd));
  // ****************************************
  // helper tasks
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe edge
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // request pulse, then sample the one-cycle answer
  task automatic dbg(input logic e, input logic p, input logic [7:0] x);
    @(posedge clk);
    erq <= e;
    prq <= p;
    @(posedge clk);
    erq <= 1'b0;
    prq <= 1'b0;
    tick(1);
    chk({5'h0, e_go, p_go, refd}, x);
  endtask
  task automatic fire(input logic [3:0] v, input logic [3:0] en);
    @(posedge clk);
    ev <= v;
    ex_en <= en;
    @(posedge clk);
    ev <= 4'h0;
    #1;
  endtask
  task automatic test_done;
    if (n_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk({7'h0, dbg_en}, 8'h01);
    // reset values, writable bits, unused bits read zero
    for (int i = 0; i < 10; i++) begin
      rd_chk(ra[i], 8'h00);
      wr_reg(ra[i], 8'hff);
      rd_chk(ra[i], rm[i]);
    end
    chk(ee_data, 8'hff);
    chk(ee_ctrl, 8'hff);
    chk({5'h0, eqn}, 8'h07);
    chk({7'h0, dbg_en}, 8'h00);
    dbg(1'b0, 1'b1, 8'h01);
    dbg(1'b1, 1'b0, 8'h01);
    for (int i = 0; i < 10; i++) wr_reg(ra[i], 8'h00);
    tick(2);
    chk({7'h0, dbg_en}, 8'h01);
    dbg(1'b0, 1'b1, 8'h02);
    dbg(1'b1, 1'b0, 8'h04);
    dbg(1'b1, 1'b1, 8'h04);
    // y pulse routing onto pin nine
    @(posedge clk);
    norm_oe <= 3'b111;
    ypul <= 1'b1;
    tick(3);
    chk({6'h0, p9o, p9e}, 8'h01);
    wr_reg(mci_pkg::ADDR_ROUTE, 8'h04);
    tick(3);
    chk({6'h0, p9o, p9e}, 8'h03);
    @(posedge clk);
    ypul <= 1'b0;
    norm_out <= 3'b100;
    tick(3);
    chk({6'h0, p9o, p9e}, 8'h01);
    // eeprom conversion of pins four and five
    @(posedge clk);
    sck <= 1'b1;
    sda_o <= 1'b1;
    sda_oe <= 1'b1;
    norm_oe <= 3'b000;
    norm_out <= 3'b000;
    pin5 <= 1'b1;
    tick(3);
    chk({4'h0, p4o, p4e, p5o, p5e}, 8'h00);
    chk({7'h0, sda_in}, 8'h01);
    wr_reg(mci_pkg::ADDR_EEX, 8'h40);
    tick(3);
    chk({4'h0, p4o, p4e, p5o, p5e}, 8'h0f);
    @(posedge clk);
    sck <= 1'b0;
    sda_o <= 1'b0;
    sda_oe <= 1'b0;
    tick(3);
    chk({4'h0, p4o, p4e, p5o, p5e}, 8'h04);
    // local and mpu enables, status, mask, clear
    wr_reg(mci_pkg::ADDR_IEN_A, 8'h03);
    wr_reg(mci_pkg::ADDR_IEN_B, 8'h30);
    wr_reg(mci_pkg::ADDR_IRQ_MASK, 8'h0f);
    for (int k = 0; k < 4; k++) begin
      fire(4'h1 << k, 4'hf);
      chk({4'h0, mpu_irq}, 8'h01 << k);
      fire(4'h1 << k, ~(4'h1 << k));
      chk({4'h0, mpu_irq}, 8'h00);
    end
    tick(1);
    chk({7'h0, irq}, 8'h01);
    rd_chk(mci_pkg::ADDR_IRQ_STAT, 8'h0f);
    wr_reg(mci_pkg::ADDR_IEN_A, 8'h00);
    wr_reg(mci_pkg::ADDR_IEN_B, 8'h00);
    fire(4'hf, 4'hf);
    chk({4'h0, mpu_irq}, 8'h00);
    wr_reg(mci_pkg::ADDR_IRQ_STAT, 8'h01);
    rd_chk(mci_pkg::ADDR_IRQ_STAT, 8'h0e);
    wr_reg(mci_pkg::ADDR_IRQ_MASK, 8'h01);
    tick(2);
    chk({7'h0, irq}, 8'h00);
    fire(4'h1, 4'h0);
    tick(1);
    chk({7'h0, irq}, 8'h01);
    wr_reg(mci_pkg::ADDR_IRQ_STAT, 8'h0f);
    tick(2);
    chk({7'h0, irq}, 8'h00);
    rd_chk(mci_pkg::ADDR_IRQ_STAT, 8'h00);
    test_done();
  end
endmodule
`default_nettype wire
